// *** usb_lowspeed_endpoint_handshake.sv ***
// status flags, endpoint-zero control and register slave of the USB function
`timescale 1ns/1ps
module usb_lowspeed_endpoint_handshake import usb_ep_pkg::*; (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic token_valid_i,
  input wire logic [1:0] token_kind_i,
  input wire logic [3:0] token_ep_i,
  input wire logic ctrl_tx_ack_i,
  input wire logic ctrl_rx_ok_i,
  input wire logic shared_tx_ack_i,
  input wire logic bus_reset_det_i,
  input wire logic eop_det_i,
  input wire logic bus_activity_i,
  output logic reply_valid_o,
  output logic [2:0] reply_code_o,
  output logic [3:0] ctrl_tx_byte_count_o,
  output logic usb_clk_stop_o,
  output logic cpu_reset_req_o,
  output logic usb_irq_o
);

  // ****************************************************
  // state
  // ****************************************************
  logic [7:0] status_ff;
  logic [7:0] nxt_status;
  logic [7:0] irq_en_ff;
  logic [7:0] nxt_irq_en;
  logic [7:0] ctrl_ff;
  logic [7:0] nxt_ctrl;
  logic shared_en_ff;
  logic nxt_shared_en;
  logic wait_ff;
  logic nxt_wait;
  logic [31:0] rdata_ff;
  logic [31:0] nxt_rdata;
  logic reply_valid_ff;
  logic nxt_reply_valid;
  logic [2:0] reply_ff;
  logic [2:0] nxt_reply;
  logic clk_stop_ff;
  logic nxt_clk_stop;
  logic rst_req_ff;
  logic nxt_rst_req;
  logic irq_ff;
  logic nxt_irq;

  logic wr_done;
  logic rd_done;
  logic wr_lane;
  logic setup_ctrl;
  logic [7:0] sets;
  logic [7:0] pending;

  ep_reply_if rif ();

  ep_reply_decide u_decide (
    .rif(rif)
  );

  assign rif.token_valid = token_valid_i;
  assign rif.token_kind = token_kind_i;
  assign rif.token_ep = token_ep_i;
  assign rif.ctrl_tx_enable = ctrl_ff[BIT_TX_EN];
  assign rif.ctrl_tx_done_flag = status_ff[BIT_CTX_DONE];
  assign rif.ctrl_rx_enable = ctrl_ff[BIT_RX_EN];
  assign rif.ctrl_rx_done_flag = status_ff[BIT_CRX_DONE];
  assign rif.ctrl_force_halt = ctrl_ff[BIT_HALT];
  assign rif.ctrl_tx_sequence = ctrl_ff[BIT_TX_SEQ];
  assign rif.shared_tx_enable = shared_en_ff;
  assign rif.shared_tx_done_flag = status_ff[BIT_STX_DONE];

  // ****************************************************
  // next values
  // ****************************************************
  always_comb begin
    // a request completes on the edge where waitrequest is low
    wr_done = avs_write_i && !wait_ff;
    rd_done = avs_read_i && !wait_ff;
    wr_lane = wr_done && avs_byteenable_i[0];
    setup_ctrl = token_valid_i && token_kind_i == TOK_SETUP && token_ep_i == EP_CTRL;
    nxt_wait = !((avs_read_i || avs_write_i) && wait_ff);

    sets = 8'h00;
    sets[BIT_BUS_RST] = bus_reset_det_i;
    sets[BIT_CTX_DONE] = ctrl_tx_ack_i;
    sets[BIT_CRX_DONE] = ctrl_rx_ok_i;
    sets[BIT_STX_DONE] = shared_tx_ack_i;
    sets[BIT_PKT_END] = eop_det_i;
    sets[BIT_WAKEUP] = bus_activity_i && status_ff[BIT_SUSPEND];

    nxt_status = status_ff;
    if (wr_lane && avs_address_i == IDX_STATUS) begin
      nxt_status = avs_writedata_i[7:0];
      nxt_status[BIT_BUS_RST] = status_ff[BIT_BUS_RST];
    end
    if (rd_done && avs_address_i == IDX_STATUS) begin
      nxt_status[BIT_BUS_RST] = 1'b0;
    end
    nxt_status = nxt_status | sets;
    nxt_status[BIT_RSV] = 1'b0;

    nxt_irq_en = irq_en_ff;
    if (wr_lane && avs_address_i == IDX_IRQ_EN) begin
      nxt_irq_en = avs_writedata_i[7:0];
    end

    nxt_ctrl = ctrl_ff;
    if (wr_lane && avs_address_i == IDX_CTRL) begin
      nxt_ctrl = avs_writedata_i[7:0];
    end
    if (setup_ctrl) begin
      nxt_ctrl[BIT_HALT] = 1'b0;
    end

    nxt_shared_en = shared_en_ff;
    if (wr_lane && avs_address_i == IDX_SHARED) begin
      nxt_shared_en = avs_writedata_i[BIT_SH_EN];
    end

    nxt_rdata = rdata_ff;
    if (avs_read_i && wait_ff) begin
      unique case (avs_address_i)
        IDX_STATUS: nxt_rdata = {24'h000000, status_ff};
        IDX_IRQ_EN: nxt_rdata = {24'h000000, irq_en_ff};
        IDX_CTRL: nxt_rdata = {24'h000000, ctrl_ff};
        IDX_SHARED: nxt_rdata = {31'h00000000, shared_en_ff};
        default: nxt_rdata = 32'h00000000;
      endcase
    end

    nxt_reply = rif.reply;
    nxt_reply_valid = rif.reply != REP_NONE;
    nxt_clk_stop = status_ff[BIT_SUSPEND];
    nxt_rst_req = bus_reset_det_i && irq_en_ff[BIT_RST_PROP];

    // per-flag enable, wake-up only while suspended
    pending = status_ff & irq_en_ff;
    pending[BIT_RSV] = 1'b0;
    pending[BIT_WAKEUP] = pending[BIT_WAKEUP] && status_ff[BIT_SUSPEND];
    nxt_irq = |pending;
  end

  // ****************************************************
  // registers
  // ****************************************************
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      status_ff <= RST_STATUS;
      irq_en_ff <= RST_IRQ_EN;
      ctrl_ff <= RST_CTRL;
      shared_en_ff <= RST_SHARED;
      wait_ff <= RST_WAIT;
      rdata_ff <= RST_RDATA;
      reply_valid_ff <= 1'b0;
      reply_ff <= REP_NONE;
      clk_stop_ff <= 1'b0;
      rst_req_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      status_ff <= nxt_status;
      irq_en_ff <= nxt_irq_en;
      ctrl_ff <= nxt_ctrl;
      shared_en_ff <= nxt_shared_en;
      wait_ff <= nxt_wait;
      rdata_ff <= nxt_rdata;
      reply_valid_ff <= nxt_reply_valid;
      reply_ff <= nxt_reply;
      clk_stop_ff <= nxt_clk_stop;
      rst_req_ff <= nxt_rst_req;
      irq_ff <= nxt_irq;
    end
  end

  assign avs_readdata_o = rdata_ff;
  assign avs_waitrequest_o = wait_ff;
  assign reply_valid_o = reply_valid_ff;
  assign reply_code_o = reply_ff;
  assign ctrl_tx_byte_count_o = ctrl_ff[3:0];
  assign usb_clk_stop_o = clk_stop_ff;
  assign cpu_reset_req_o = rst_req_ff;
  assign usb_irq_o = irq_ff;

  // ****************************************************
  // checks
  // ****************************************************
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  a_suspend_clock_stop: assert property (
    status_ff[BIT_SUSPEND] |-> ##1 usb_clk_stop_o)
    else $error("clock not stopped in suspend");
  a_bus_reset_flag: assert property (
    bus_reset_det_i |=> status_ff[BIT_BUS_RST])
    else $error("bus reset flag not set");
  a_reset_propagate: assert property (
    bus_reset_det_i && irq_en_ff[BIT_RST_PROP] |=> cpu_reset_req_o)
    else $error("bus reset not propagated");
  a_ctrl_tx_done: assert property (
    ctrl_tx_ack_i |=> status_ff[BIT_CTX_DONE])
    else $error("ctrl tx done not set");
  a_in_nak_reply: assert property (
    token_valid_i && token_kind_i == TOK_IN && token_ep_i == EP_CTRL &&
    !ctrl_ff[BIT_HALT] && (!ctrl_ff[BIT_TX_EN] || status_ff[BIT_CTX_DONE])
    |=> reply_valid_o && reply_code_o == REP_NAK)
    else $error("ctrl IN not answered NAK");
  a_ctrl_rx_done: assert property (
    ctrl_rx_ok_i |=> status_ff[BIT_CRX_DONE])
    else $error("ctrl rx done not set");
  a_out_nak_reply: assert property (
    token_valid_i && token_kind_i == TOK_OUT && token_ep_i == EP_CTRL &&
    !ctrl_ff[BIT_HALT] && (!ctrl_ff[BIT_RX_EN] || status_ff[BIT_CRX_DONE])
    |=> reply_code_o == REP_NAK)
    else $error("ctrl OUT not answered NAK");
  a_shared_done_nak: assert property (
    token_valid_i && token_kind_i == TOK_IN &&
    (token_ep_i == EP_ONE || token_ep_i == EP_TWO) &&
    status_ff[BIT_STX_DONE] |=> reply_code_o == REP_NAK)
    else $error("shared IN not NAK");
  a_shared_tx_done: assert property (
    shared_tx_ack_i |=> status_ff[BIT_STX_DONE])
    else $error("shared tx done not set");
  a_packet_end_flag: assert property (
    eop_det_i |=> status_ff[BIT_PKT_END])
    else $error("end of packet flag not set");
  a_wakeup_flag: assert property (
    bus_activity_i && status_ff[BIT_SUSPEND] |=> status_ff[BIT_WAKEUP])
    else $error("wake-up flag not set");
  a_data_pid_pick: assert property (
    token_valid_i && token_kind_i == TOK_IN && token_ep_i == EP_CTRL && !ctrl_ff[BIT_HALT] &&
    ctrl_ff[BIT_TX_EN] && !status_ff[BIT_CTX_DONE]
    |=> reply_code_o == ($past(ctrl_ff[BIT_TX_SEQ]) ? REP_DATA1 : REP_DATA0))
    else $error("wrong data pid");
  a_halt_stall_reply: assert property (
    token_valid_i && (token_kind_i == TOK_IN || token_kind_i == TOK_OUT) &&
    token_ep_i == EP_CTRL && ctrl_ff[BIT_HALT]
    |=> reply_code_o == REP_STALL)
    else $error("halt not answered STALL");
  a_setup_clears_halt: assert property (
    token_valid_i && token_kind_i == TOK_SETUP && token_ep_i == EP_CTRL
    |=> !ctrl_ff[BIT_HALT])
    else $error("setup did not clear halt");
  a_irq_raised: assert property (
    (status_ff[7:1] & irq_en_ff[7:1]) != 7'h00 ||
    (status_ff[BIT_WAKEUP] && irq_en_ff[BIT_WAKEUP] && status_ff[BIT_SUSPEND])
    |=> usb_irq_o)
    else $error("interrupt not raised");
  a_irq_dropped: assert property (
    (status_ff[7:1] & irq_en_ff[7:1]) == 7'h00 &&
    !(status_ff[BIT_WAKEUP] && irq_en_ff[BIT_WAKEUP] && status_ff[BIT_SUSPEND])
    |=> !usb_irq_o)
    else $error("interrupt not dropped");
  a_rx_accept_ack: assert property (
    token_valid_i && token_kind_i == TOK_OUT && token_ep_i == EP_CTRL &&
    !ctrl_ff[BIT_HALT] && ctrl_ff[BIT_RX_EN] && !status_ff[BIT_CRX_DONE]
    |=> reply_valid_o && reply_code_o == REP_ACK)
    else $error("ctrl OUT not accepted");
  a_setup_ack_reply: assert property (
    token_valid_i && token_kind_i == TOK_SETUP && token_ep_i == EP_CTRL
    |=> reply_valid_o && reply_code_o == REP_ACK)
    else $error("setup not answered ACK");
  a_byte_count_load: assert property (
    wr_lane && avs_address_i == IDX_CTRL
    |=> ctrl_tx_byte_count_o == $past(avs_writedata_i[3:0]))
    else $error("byte count not loaded");
  a_flag_clear_write: assert property (
    wr_lane && avs_address_i == IDX_STATUS && !avs_writedata_i[BIT_PKT_END] && !eop_det_i
    |=> !status_ff[BIT_PKT_END])
    else $error("flag clear lost");
  a_bus_reset_read_only: assert property (
    wr_lane && avs_address_i == IDX_STATUS && !bus_reset_det_i && !status_ff[BIT_BUS_RST]
    |=> !status_ff[BIT_BUS_RST])
    else $error("bus reset flag written");
  a_reset_req_drop: assert property (
    !(bus_reset_det_i && irq_en_ff[BIT_RST_PROP]) |=> !cpu_reset_req_o)
    else $error("spurious reset request");
  a_clock_runs_awake: assert property (
    !status_ff[BIT_SUSPEND] |=> !usb_clk_stop_o)
    else $error("clock stopped while awake");

  // bus handshake: one wait state, then a single low cycle
  a_wait_one_state: assert property (
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("request not answered");
  a_wait_low_pulse: assert property (
    !avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low too long");

endmodule

// *** usb_ep_pkg.sv ***
// constants and encodings for the low-speed endpoint handshake block
// Behaviour
// - set suspend flag stops the USB clock
// - bus reset detect sets read-only flag bit5
// - reset enable propagates bus reset to system
// - acked endpoint-zero transmit sets done bit4
// - NAK IN when tx disabled or done
// - acked endpoint-zero receive sets done bit3
// - NAK OUT when rx disabled or done
// - shared endpoint transmit ack sets bit2
// - shared done flag set means NAK IN
// - end of packet sets bit1, software clears
// - activity during suspend sets wake-up bit0
// - sequence bit picks DATA0 or DATA1
// - halt bit answers IN/OUT with STALL
// - SETUP token clears the halt bit
// - receive enable bit4 permits OUT data
// - bits3..0 hold tx byte count, reset clears
// - each flag has an enable bit
package usb_ep_pkg;

  // ****************************************************
  // register indexes, byte address is four times these
  // ****************************************************
  localparam logic [7:0] IDX_STATUS = 8'hE8;
  localparam logic [7:0] IDX_IRQ_EN = 8'hE9;
  localparam logic [7:0] IDX_CTRL = 8'hEA;
  localparam logic [7:0] IDX_SHARED = 8'hF0;

  // ****************************************************
  // field positions
  // ****************************************************
  localparam int BIT_SUSPEND = 7;
  localparam int BIT_RSV = 6;
  localparam int BIT_BUS_RST = 5;
  localparam int BIT_CTX_DONE = 4;
  localparam int BIT_CRX_DONE = 3;
  localparam int BIT_STX_DONE = 2;
  localparam int BIT_PKT_END = 1;
  localparam int BIT_WAKEUP = 0;
  localparam int BIT_RST_PROP = 6;
  localparam int BIT_TX_SEQ = 7;
  localparam int BIT_HALT = 6;
  localparam int BIT_TX_EN = 5;
  localparam int BIT_RX_EN = 4;
  localparam int BIT_SH_EN = 0;

  // ****************************************************
  // reset values
  // ****************************************************
  localparam logic [7:0] RST_STATUS = 8'h00;
  localparam logic [7:0] RST_IRQ_EN = 8'h00;
  localparam logic [7:0] RST_CTRL = 8'h00;
  localparam logic RST_SHARED = 1'b0;
  localparam logic RST_WAIT = 1'b1;
  localparam logic [31:0] RST_RDATA = 32'h00000000;

  // ****************************************************
  // token kinds and reply codes
  // ****************************************************
  localparam logic [1:0] TOK_IN = 2'h1;
  localparam logic [1:0] TOK_OUT = 2'h2;
  localparam logic [1:0] TOK_SETUP = 2'h3;
  localparam logic [3:0] EP_CTRL = 4'h0;
  localparam logic [3:0] EP_ONE = 4'h1;
  localparam logic [3:0] EP_TWO = 4'h2;
  localparam logic [2:0] REP_NONE = 3'h0;
  localparam logic [2:0] REP_ACK = 3'h1;
  localparam logic [2:0] REP_NAK = 3'h2;
  localparam logic [2:0] REP_STALL = 3'h3;
  localparam logic [2:0] REP_DATA0 = 3'h4;
  localparam logic [2:0] REP_DATA1 = 3'h5;

endpackage

// *** ep_reply_if.sv ***
// carrier between the register owner and the reply decider
`timescale 1ns/1ps
interface ep_reply_if;
  import usb_ep_pkg::*;
  logic token_valid;
  logic [1:0] token_kind;
  logic [3:0] token_ep;
  logic ctrl_tx_enable;
  logic ctrl_tx_done_flag;
  logic ctrl_rx_enable;
  logic ctrl_rx_done_flag;
  logic ctrl_force_halt;
  logic ctrl_tx_sequence;
  logic shared_tx_enable;
  logic shared_tx_done_flag;
  logic [2:0] reply;
  modport owner (output token_valid, token_kind, token_ep, ctrl_tx_enable, ctrl_tx_done_flag,
    ctrl_rx_enable, ctrl_rx_done_flag, ctrl_force_halt, ctrl_tx_sequence, shared_tx_enable,
    shared_tx_done_flag, input reply);
  modport decider (input token_valid, token_kind, token_ep, ctrl_tx_enable, ctrl_tx_done_flag,
    ctrl_rx_enable, ctrl_rx_done_flag, ctrl_force_halt, ctrl_tx_sequence, shared_tx_enable,
    shared_tx_done_flag, output reply);
endinterface

// *** ep_reply_decide.sv ***
// handshake choice for IN, OUT and SETUP tokens
`timescale 1ns/1ps
module ep_reply_decide import usb_ep_pkg::*; (
  ep_reply_if.decider rif
);

  logic in_ok;
  logic out_ok;

  always_comb begin
    in_ok = rif.ctrl_tx_enable && !rif.ctrl_tx_done_flag;
    out_ok = rif.ctrl_rx_enable && !rif.ctrl_rx_done_flag;
    rif.reply = REP_NONE;
    if (rif.token_valid && rif.token_ep == EP_CTRL) begin
      unique case (rif.token_kind)
        TOK_SETUP: begin
          rif.reply = REP_ACK;
        end
        TOK_IN: begin
          if (rif.ctrl_force_halt) begin
            rif.reply = REP_STALL;
          end else if (!in_ok) begin
            rif.reply = REP_NAK;
          end else begin
            rif.reply = rif.ctrl_tx_sequence ? REP_DATA1 : REP_DATA0;
          end
        end
        TOK_OUT: begin
          if (rif.ctrl_force_halt) begin
            rif.reply = REP_STALL;
          end else if (!out_ok) begin
            rif.reply = REP_NAK;
          end else begin
            rif.reply = REP_ACK;
          end
        end
        default: begin
          rif.reply = REP_NONE;
        end
      endcase
    end else if (rif.token_valid && rif.token_kind == TOK_IN &&
                 (rif.token_ep == EP_ONE || rif.token_ep == EP_TWO)) begin
      if (rif.shared_tx_done_flag || !rif.shared_tx_enable) begin
        rif.reply = REP_NAK;
      end else begin
        rif.reply = REP_DATA0;
      end
    end
  end

endmodule

// *** usb_host_model.sv ***
// host-side model issuing tokens and bus events to the endpoint block
`timescale 1ns/1ps
module usb_host_model (
  input wire logic clk_i,
  output logic token_valid_o,
  output logic [1:0] token_kind_o,
  output logic [3:0] token_ep_o,
  output logic [5:0] event_o
);
  // ****************************************************
  // token and event pulses, one cycle each
  // ****************************************************
  initial begin
    token_valid_o = 1'b0;
    token_kind_o = 2'h0;
    token_ep_o = 4'h0;
    event_o = 6'h00;
  end

  // released fields flip so stale values never look valid
  task automatic token(input logic [1:0] k, input logic [3:0] e);
    @(posedge clk_i);
    token_valid_o <= 1'b1;
    token_kind_o <= k;
    token_ep_o <= e;
    @(posedge clk_i);
    token_valid_o <= 1'b0;
    token_kind_o <= ~k;
    token_ep_o <= ~e;
  endtask

  // event bits: 0 ctrl ack, 1 ctrl rx ok, 2 shared ack, 3 bus reset, 4 eop, 5 activity
  task automatic pulse(input int b);
    @(posedge clk_i);
    event_o[b] <= 1'b1;
    @(posedge clk_i);
    event_o[b] <= 1'b0;
  endtask
endmodule

// *** test_usb_lowspeed_endpoint_handshake.sv ***
// self-checking bench for the endpoint handshake block
`timescale 1ns/1ps
module test_usb_lowspeed_endpoint_handshake import usb_ep_pkg::*;;
  logic sys_clk_i;
  logic rst_b_i;
  logic [7:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic token_valid_i;
  logic [1:0] token_kind_i;
  logic [3:0] token_ep_i;
  logic [5:0] ev;
  logic reply_valid_o;
  logic [2:0] reply_code_o;
  logic [3:0] ctrl_tx_byte_count_o;
  logic usb_clk_stop_o;
  logic cpu_reset_req_o;
  logic usb_irq_o;
  logic [31:0] rd;
  int n_mismatch = 0;
  int comparisons = 0;

  usb_lowspeed_endpoint_handshake uut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .token_valid_i(token_valid_i), .token_kind_i(token_kind_i), .token_ep_i(token_ep_i),
    .ctrl_tx_ack_i(ev[0]), .ctrl_rx_ok_i(ev[1]), .shared_tx_ack_i(ev[2]),
    .bus_reset_det_i(ev[3]), .eop_det_i(ev[4]), .bus_activity_i(ev[5]),
    .reply_valid_o(reply_valid_o), .reply_code_o(reply_code_o),
    .ctrl_tx_byte_count_o(ctrl_tx_byte_count_o), .usb_clk_stop_o(usb_clk_stop_o),
    .cpu_reset_req_o(cpu_reset_req_o), .usb_irq_o(usb_irq_o));

  usb_host_model host (.clk_i(sys_clk_i), .token_valid_o(token_valid_i),
    .token_kind_o(token_kind_i), .token_ep_o(token_ep_i), .event_o(ev));

  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  // ****************************************************
  // report, compare and bus tasks
  // ****************************************************
  task automatic final_report();
    $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
    if (n_mismatch == 0 && comparisons > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // request held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      input logic [3:0] be);
    int n;
    n = 0;
    @(posedge sys_clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= {~d, ~d, ~d, d};
    avs_byteenable_i <= be;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 20);
    if (avs_waitrequest_o !== 1'b0) begin
      n_mismatch++;
      final_report();
    end
    rd = avs_readdata_o;
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdc(input string what, input logic [7:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    check(what, rd, {24'h000000, exp});
  endtask

  task automatic tok(input logic [1:0] k, input logic [3:0] e, input logic [2:0] exp);
    host.token(k, e);
    #1;
    check("reply_valid", reply_valid_o, 32'h1);
    check("reply_code", reply_code_o, exp);
  endtask

  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    rst_b_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    repeat (12) @(posedge sys_clk_i);
    rst_b_i <= 1'b1;
    rdc("status", IDX_STATUS, 8'h00);
    rdc("irq_en", IDX_IRQ_EN, 8'h00);
    rdc("unmapped", 8'h10, 8'h00);
    wr(8'h10, 8'hFF);
    bus(1'b1, IDX_CTRL, 8'hFF, 4'hE);
    rdc("ctrl", IDX_CTRL, 8'h00);
    wr(IDX_CTRL, 8'h2A);
    rdc("ctrl", IDX_CTRL, 8'h2A);
    check("byte_count", ctrl_tx_byte_count_o, 32'hA);
    tok(TOK_IN, EP_CTRL, REP_DATA0);
    wr(IDX_CTRL, 8'hA0);
    tok(TOK_IN, EP_CTRL, REP_DATA1);
    wr(IDX_CTRL, 8'h80);
    tok(TOK_IN, EP_CTRL, REP_NAK);
    tok(TOK_OUT, EP_CTRL, REP_NAK);
    wr(IDX_CTRL, 8'h30);
    tok(TOK_OUT, EP_CTRL, REP_ACK);
    host.pulse(0);
    rdc("status", IDX_STATUS, 8'h10);
    tok(TOK_IN, EP_CTRL, REP_NAK);
    host.pulse(1);
    rdc("status", IDX_STATUS, 8'h18);
    tok(TOK_OUT, EP_CTRL, REP_NAK);
    wr(IDX_STATUS, 8'h00);
    rdc("status", IDX_STATUS, 8'h00);
    tok(TOK_OUT, EP_CTRL, REP_ACK);
    wr(IDX_CTRL, 8'h70);
    tok(TOK_IN, EP_CTRL, REP_STALL);
    tok(TOK_OUT, EP_CTRL, REP_STALL);
    tok(TOK_SETUP, EP_CTRL, REP_ACK);
    rdc("ctrl", IDX_CTRL, 8'h30);
    wr(IDX_SHARED, 8'h01);
    tok(TOK_IN, EP_ONE, REP_DATA0);
    host.pulse(2);
    rdc("status", IDX_STATUS, 8'h04);
    tok(TOK_IN, EP_TWO, REP_NAK);
    host.token(TOK_OUT, EP_ONE);
    #1;
    check("no_reply", reply_valid_o, 32'h0);
    wr(IDX_IRQ_EN, 8'h02);
    host.pulse(4);
    rdc("status", IDX_STATUS, 8'h06);
    check("irq", usb_irq_o, 32'h1);
    wr(IDX_STATUS, 8'h00);
    rdc("status", IDX_STATUS, 8'h00);
    check("irq", usb_irq_o, 32'h0);
    host.pulse(5);
    rdc("status", IDX_STATUS, 8'h00);
    wr(IDX_STATUS, 8'h80);
    rdc("status", IDX_STATUS, 8'h80);
    check("clk_stop", usb_clk_stop_o, 32'h1);
    host.pulse(5);
    rdc("status", IDX_STATUS, 8'h81);
    wr(IDX_STATUS, 8'h00);
    rdc("status", IDX_STATUS, 8'h00);
    check("clk_stop", usb_clk_stop_o, 32'h0);
    wr(IDX_IRQ_EN, 8'h40);
    host.pulse(3);
    #1;
    check("cpu_reset", cpu_reset_req_o, 32'h1);
    rdc("status", IDX_STATUS, 8'h20);
    rdc("status", IDX_STATUS, 8'h00);
    // mid-run reset clears the byte count
    wr(IDX_CTRL, 8'h2F);
    rdc("ctrl", IDX_CTRL, 8'h2F);
    @(posedge sys_clk_i);
    rst_b_i <= 1'b0;
    repeat (3) @(posedge sys_clk_i);
    check("byte_count", ctrl_tx_byte_count_o, 32'h0);
    check("waitrequest", avs_waitrequest_o, 32'h1);
    rst_b_i <= 1'b1;
    rdc("ctrl", IDX_CTRL, 8'h00);
    rdc("irq_en", IDX_IRQ_EN, 8'h00);
    final_report();
  end
endmodule
